// file: flash_lock_suspend_command_logic.sv
// command interface and write state machine: suspend/resume, lock bits, protection, pin config
`timescale 1ns/100ps
`default_nettype none
module flash_lock_suspend_command_logic #(
  parameter int NBLK = 32,
  parameter int BLK_LSB = 11
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // device pins from the board
  input wire logic reset_powerdown_n,
  input wire logic write_protect_n,
  input wire logic vpp_lockout,
  output logic completion_indicator_pin,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // array side: array data in, operation request and erase mask out
  input wire logic [15:0] array_data,
  output logic [15:0] array_addr,
  output logic array_busy,
  output logic [NBLK-1:0] erase_mask
);
  // wait states hold the first cycle of a command pair until its second cycle lands
  typedef enum logic [2:0] {
    S_READY, S_PROG_WAIT, S_ERASE_WAIT, S_LOCK_WAIT, S_CFG_WAIT, S_BUSY, S_PSUSP
  } state_t;

  // pin synchronisers; the supply flag resets to lockout so nothing starts before it settles
  logic [1:0] pd_sync_q, wp_sync_q, vpp_sync_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pd_sync_q <= 2'h0;
      wp_sync_q <= 2'h0;
      vpp_sync_q <= 2'h3;
    end else begin
      pd_sync_q <= {pd_sync_q[0], reset_powerdown_n};
      wp_sync_q <= {wp_sync_q[0], write_protect_n};
      vpp_sync_q <= {vpp_sync_q[0], vpp_lockout};
    end
  end
  wire pd_ok = pd_sync_q[1];
  wire wp_high = wp_sync_q[1];
  wire vpp_low = vpp_sync_q[1];

  // bus request decode; one wait state so every access answers on its second edge
  // writes land on the edge where waitrequest is low, reads launch one edge earlier
  logic ack_q;
  logic wait_q;
  wire req = (read || write) && !ack_q;
  flash_cmd_pkg::cmd_t cmd;
  logic [15:0] addr_q;
  assign cmd.valid = write && ack_q && (address == flash_cmd_pkg::REG_CMD);
  assign cmd.code = writedata[7:0];
  assign cmd.addr = addr_q;
  wire addr_wr = write && ack_q && (address == flash_cmd_pkg::REG_ADDR);

  // command-side state
  state_t state_q, state_d;
  logic [7:0] sr_q;
  logic [NBLK-1:0] lock_q;
  logic [1:0] cfg_q;
  logic read_status_q;
  logic [15:0] tgt_q;
  logic [2:0] op_q; // 0 prog, 1 erase, 2 chip, 3 lock set, 4 lock clear
  logic [NBLK-1:0] emask_q;

  // block index of an address, used for lock lookup in several places
  function automatic logic [$clog2(NBLK)-1:0] blk(input logic [15:0] a);
    blk = a[BLK_LSB +: $clog2(NBLK)];
  endfunction

  wire is_cmd = cmd.valid;
  wire c = is_cmd;
  wire [7:0] code = cmd.code;
  wire write_ok = !lock_q[blk(cmd.addr)] || wp_high;
  wire op_start = (state_q == S_PROG_WAIT || state_q == S_ERASE_WAIT || state_q == S_LOCK_WAIT)
                  && c && state_d == S_BUSY;
  logic op_done;
  wire in_susp = (state_q == S_PSUSP);
  // in suspend only read array, read status and resume count; the rest is dropped
  wire susp_ok = (code == flash_cmd_pkg::CMD_READ_ARRAY) || (code == flash_cmd_pkg::CMD_CONFIRM)
                 || (code == flash_cmd_pkg::CMD_READ_STATUS);
  wire mode_wr = c && (!in_susp || susp_ok);

  // after an abort the timer runs on alone; its done is ignored outside busy
  op_timer u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .start(op_start),
    .hold(in_susp),
    .done(op_done)
  );

  // next state of the command interface
  // wait states go to busy on a good second cycle and fall back to ready on a bad one; config wait always returns to ready
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_READY: if (c) begin
        if (code == flash_cmd_pkg::CMD_PROGRAM || code == flash_cmd_pkg::CMD_PROGRAM_ALT)
          state_d = S_PROG_WAIT;
        else if (code == flash_cmd_pkg::CMD_ERASE || code == flash_cmd_pkg::CMD_CHIP_ERASE)
          state_d = S_ERASE_WAIT;
        else if (code == flash_cmd_pkg::CMD_LOCK_SETUP) state_d = S_LOCK_WAIT;
        else if (code == flash_cmd_pkg::CMD_PIN_CONFIG) state_d = S_CFG_WAIT;
      end
      S_PROG_WAIT: if (c) state_d = (sr_q[flash_cmd_pkg::SR_PGM_ERR] || vpp_low || !write_ok)
                                    ? S_READY : S_BUSY;
      S_ERASE_WAIT: if (c) state_d = (code == flash_cmd_pkg::CMD_CONFIRM && !vpp_low &&
                                     (write_ok || op_q == 3'd2)) ? S_BUSY : S_READY;
      S_LOCK_WAIT: if (c) state_d = ((code == flash_cmd_pkg::CMD_LOCK_SET ||
                                     code == flash_cmd_pkg::CMD_CONFIRM) && wp_high && !vpp_low)
                                    ? S_BUSY : S_READY;
      S_CFG_WAIT: if (c) state_d = S_READY;
      S_BUSY: begin
        // a finish in the suspend cycle wins, else the frozen count would never end
        if (op_done) state_d = S_READY;
        else if (c && code == flash_cmd_pkg::CMD_SUSPEND && op_q == 3'd0) state_d = S_PSUSP;
      end
      S_PSUSP: if (c && code == flash_cmd_pkg::CMD_CONFIRM) state_d = S_BUSY;
    endcase
    if (!pd_ok) state_d = S_READY;
  end

  // state, target and operation kind
  // op_q latches on the first cycle of a pair and again on the second for lock pairs, tgt_q on the second
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_READY;
      tgt_q <= 16'h0000;
      op_q <= 3'd0;
    end else begin
      state_q <= state_d;
      if (c && state_q == S_READY) begin
        op_q <= (code == flash_cmd_pkg::CMD_ERASE) ? 3'd1 :
                (code == flash_cmd_pkg::CMD_CHIP_ERASE) ? 3'd2 : 3'd0;
      end
      if (c && state_q == S_LOCK_WAIT) op_q <= (code == flash_cmd_pkg::CMD_LOCK_SET) ? 3'd3 : 3'd4;
      if (c && state_q != S_READY && state_q != S_BUSY && state_q != S_PSUSP) tgt_q <= cmd.addr;
    end
  end

  // status register: hardware sets win over a clear in the same cycle
  logic [7:0] sr_set, sr_clr;
  always_comb begin
    sr_set = 8'h00;
    sr_clr = 8'h00;
    // a clear in suspend would drop the suspend flag, so it is refused there
    if (c && code == flash_cmd_pkg::CMD_CLEAR_STATUS && state_q == S_READY)
      sr_clr = 8'h3E;
    if (state_d == S_BUSY && state_q != S_BUSY) sr_clr[flash_cmd_pkg::SR_READY] = 1'b1;
    if (in_susp && state_d == S_BUSY) sr_clr[flash_cmd_pkg::SR_PSUSP] = 1'b1;
    // a parked program reads as ready plus suspended, so a poll on bit 7 ends
    if (state_q == S_BUSY && state_d == S_PSUSP) begin
      sr_set[flash_cmd_pkg::SR_PSUSP] = 1'b1;
      sr_set[flash_cmd_pkg::SR_READY] = 1'b1;
    end
    if (state_q != S_READY && state_d == S_READY) sr_set[flash_cmd_pkg::SR_READY] = 1'b1;
    // lock second cycle: bad code first, then protect, then supply
    if (c && state_q == S_LOCK_WAIT) begin
      if (code != flash_cmd_pkg::CMD_LOCK_SET && code != flash_cmd_pkg::CMD_CONFIRM)
        sr_set = sr_set | 8'h30;
      else if (!wp_high) sr_set = sr_set | 8'h12;
      else if (vpp_low) sr_set = sr_set | 8'h28;
    end
    // program second cycle carries the data, so any code is a valid second cycle
    if (c && state_q == S_PROG_WAIT) begin
      if (vpp_low) sr_set = sr_set | 8'h18;
      else if (!write_ok) sr_set = sr_set | 8'h12;
    end
    // chip erase ignores lock bits here; the mask sorts them out at the end
    if (c && state_q == S_ERASE_WAIT) begin
      if (code != flash_cmd_pkg::CMD_CONFIRM) sr_set = sr_set | 8'h30;
      else if (vpp_low) sr_set = sr_set | 8'h28;
      else if (!write_ok && op_q != 3'd2) sr_set = sr_set | 8'h22;
    end
    if (c && state_q == S_CFG_WAIT && code[7:2] != 6'h00) sr_set = sr_set | 8'h30;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sr_q <= flash_cmd_pkg::SR_RESET;
    end else begin
      // set applied after clear so a hardware event is never lost to a host clear
      sr_q <= (sr_q & ~sr_clr) | sr_set;
    end
  end

  // read mode: status after every operation, array on explicit read array
  // a command refused in suspend leaves the mode alone
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      read_status_q <= 1'b0;
    end else if (mode_wr) begin
      read_status_q <= (code != flash_cmd_pkg::CMD_READ_ARRAY);
    end
  end

  // lock bits and block or chip erase mask; clear all at once with protect high
  // lock bits are volatile here; an aborted operation leaves them as they were
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lock_q <= '0;
      emask_q <= '0;
    end else if (op_done && state_q == S_BUSY) begin
      if (op_q == 3'd3) lock_q[blk(tgt_q)] <= 1'b1;
      if (op_q == 3'd4) lock_q <= '0;
      emask_q <= (op_q == 3'd2) ? (wp_high ? '1 : ~lock_q) :
                 (op_q == 3'd1) ? (NBLK'(1) << blk(tgt_q)) : '0;
    end else begin
      emask_q <= '0;
    end
  end

  // configuration byte, only low two bits kept
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= flash_cmd_pkg::PIN_LEVEL;
    end else if (!pd_ok) begin
      cfg_q <= flash_cmd_pkg::PIN_LEVEL;
    end else if (c && state_q == S_CFG_WAIT && code[7:2] == 6'h00) begin
      cfg_q <= code[1:0];
    end
  end

  // completion pulse on the selected event
  // back-to-back completions retrigger and only stretch the pulse
  wire done_evt = op_done && state_q == S_BUSY;
  wire fire = done_evt &&
              ((cfg_q[flash_cmd_pkg::PIN_ERASE_BIT] && (op_q == 3'd1 || op_q == 3'd2)) ||
               (cfg_q[flash_cmd_pkg::PIN_PROG_BIT] && op_q == 3'd0));
  logic pulse_on;
  pulse_gen u_pulse (
    .mclk(mclk),
    .rstn(rstn),
    .fire(fire),
    .active(pulse_on)
  );

  // registered outputs; pin low while busy in level mode, else low during pulse
  wire busy_d = (state_d == S_BUSY);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      completion_indicator_pin <= 1'b1;
      array_busy <= 1'b0;
      array_addr <= 16'h0000;
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      addr_q <= 16'h0000;
      readdata <= 32'h0000_0000;
    end else begin
      completion_indicator_pin <= (cfg_q == flash_cmd_pkg::PIN_LEVEL) ? !busy_d
                                   : !pulse_on;
      array_busy <= busy_d;
      // in suspend the host address reaches the array; the target waits in tgt_q
      array_addr <= (state_q == S_BUSY) ? tgt_q : addr_q;
      ack_q <= req;
      wait_q <= !req;
      if (addr_wr) addr_q <= writedata[15:0];
      if (read && !ack_q) begin
        unique case (address)
          flash_cmd_pkg::REG_READ:
            readdata <= read_status_q ? {24'h0, sr_q} : {16'h0, array_data};
          flash_cmd_pkg::REG_ADDR: readdata <= {16'h0, addr_q};
          flash_cmd_pkg::REG_LOCKS: readdata <= 32'(lock_q);
          default: readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign erase_mask = emask_q;
  assign waitrequest = wait_q;
endmodule : flash_lock_suspend_command_logic
`default_nettype wire

// file: flash_cmd_pkg.sv
// package: command codes, status bits, bus map and timing for the lock/suspend sequencer
package flash_cmd_pkg;

  // command codes written by the host
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_SET = 8'h01;
  localparam logic [7:0] CMD_PIN_CONFIG = 8'hB8;

  // status bit positions
  localparam int SR_PROT = 1;
  localparam int SR_PSUSP = 2;
  localparam int SR_VPP = 3;
  localparam int SR_PGM_ERR = 4;
  localparam int SR_ERA_ERR = 5;
  localparam int SR_ESUSP = 6;
  localparam int SR_READY = 7;
  localparam logic [7:0] SR_RESET = 8'h80;

  // pin configuration codes (low two bits only)
  localparam logic [1:0] PIN_LEVEL = 2'h0;
  localparam int PIN_ERASE_BIT = 0;
  localparam int PIN_PROG_BIT = 1;

  // register map, byte addresses on the avalon slave
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_READ = 4'h8;
  localparam logic [3:0] REG_LOCKS = 4'hC;

  // timing at 250 MHz
  localparam int CLK_MHZ = 250;
  localparam int PULSE_NS = 250;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ) / 1000;
  localparam int OP_CYC = 64;

  // decoded host command, travels from bus slave to sequencer
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [15:0] addr;
  } cmd_t;

endpackage : flash_cmd_pkg

// file: pulse_gen.sv
// low-going completion pulse timer for the indicator pin
`timescale 1ns/100ps
`default_nettype none
module pulse_gen #(
  parameter int WIDTH = flash_cmd_pkg::PULSE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // trigger and pulse
  input wire logic fire,
  output logic active
);
  logic [15:0] cnt_q;

  // retrigger restarts the full width
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 16'h0000;
    end else if (fire) begin
      cnt_q <= 16'(WIDTH);
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  assign active = (cnt_q != 16'h0000);
endmodule : pulse_gen
`default_nettype wire

// file: op_timer.sv
// fixed-length timer standing in for the embedded array algorithms
`timescale 1ns/100ps
`default_nettype none
module op_timer #(
  parameter int CYCLES = flash_cmd_pkg::OP_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic hold,
  output logic done
);
  logic [15:0] cnt_q;

  // hold freezes the count, which is how a suspend parks the algorithm
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 16'h0000;
    end else if (start) begin
      cnt_q <= 16'(CYCLES);
    end else if (!hold && cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  assign done = !hold && (cnt_q == 16'h0001);
endmodule : op_timer
`default_nettype wire

// file: flash_lock_monitor.sv
// checker: bus handshake, indicator pin timing and erase mask pulse
`timescale 1ns/100ps
`default_nettype none
module flash_lock_monitor #(
  parameter int NBLK = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // pin and array side
  input wire logic completion_indicator_pin,
  input wire logic array_busy,
  input wire logic [NBLK-1:0] erase_mask
);
  logic pend_q;
  logic [1:0] cfg_q;
  logic [7:0] low_q;
  wire take = write && !waitrequest && address == flash_cmd_pkg::REG_CMD;
  wire pin = completion_indicator_pin;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // shadow of the pin mode; a config pair is two command writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
      cfg_q <= 2'h0;
    end else if (take) begin
      pend_q <= !pend_q && writedata[7:0] == flash_cmd_pkg::CMD_PIN_CONFIG;
      if (pend_q && writedata[7:2] == 6'h00) cfg_q <= writedata[1:0];
    end
  end

  // length of the current low stretch, saturates so it cannot wrap
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) low_q <= 8'h0;
    else if (pin) low_q <= 8'h0;
    else if (low_q != 8'hFF) low_q <= low_q + 8'h1;
  end

  a_wait_drops: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest stayed high after a request");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property (!waitrequest |-> $past(read || write) && $past(waitrequest))
    else $error("waitrequest low without a request");
  a_read_hold: assert property ($changed(readdata) |-> $past(read))
    else $error("readdata changed without a read");
  a_mask_pulse: assert property (|erase_mask |=> erase_mask == '0)
    else $error("erase mask held longer than one cycle");
  a_level_busy: assert property (cfg_q == 2'h0 && $rose(array_busy) |=> !pin)
    else $error("pin not low after busy rose");
  a_level_ready: assert property (cfg_q == 2'h0 && !array_busy [*3] |-> pin)
    else $error("pin low while idle in level mode");
  a_pulse_len: assert property (cfg_q != 2'h0 && $rose(pin) |->
    low_q >= flash_cmd_pkg::PULSE_CYC - 2 && low_q <= flash_cmd_pkg::PULSE_CYC + 2)
    else $error("pulse width wrong");
  a_pulse_ends: assert property (cfg_q != 2'h0 && $fell(pin) |-> ##[1:70] pin)
    else $error("pulse did not end");

  c_pulse: cover property (cfg_q != 2'h0 && $rose(pin));
  c_erase: cover property (|erase_mask);
  c_busy: cover property (cfg_q == 2'h0 && $rose(array_busy));
endmodule : flash_lock_monitor
`default_nettype wire

// file: flash_array_model.sv
// array model: answers each address with its own pattern
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
  // address from the design
  input wire logic [15:0] array_addr,
  // data back
  output logic [15:0] array_data
);
  // pattern differs per address so a stale or wrong read shows
  assign array_data = array_addr ^ 16'hA5C3;
endmodule : flash_array_model
`default_nettype wire

// file: flash_lock_suspend_command_logic_test.sv
// testbench: command sequences over the bus, checks status, lock bits and pin
`timescale 1ns/100ps
`default_nettype none
module flash_lock_suspend_command_logic_test;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic reset_powerdown_n = 1'b1;
  logic write_protect_n = 1'b1;
  logic vpp_lockout = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic completion_indicator_pin, waitrequest, array_busy, pl;
  logic [31:0] readdata, q, erase_mask, mask_seen;
  logic [15:0] array_data, array_addr;
  int n_fail = 0;
  int comparisons = 0;

  flash_lock_suspend_command_logic #(.NBLK(32), .BLK_LSB(11)) flash_lock_suspend_command_logic_inst (
    .mclk, .rstn, .reset_powerdown_n, .write_protect_n, .vpp_lockout, .completion_indicator_pin,
    .address, .read, .write, .writedata, .readdata, .waitrequest,
    .array_data, .array_addr, .array_busy, .erase_mask);
  flash_array_model flash_array_model_inst (.array_addr, .array_data);

  always #2 mclk = ~mclk;
  // catch one-cycle mask pulses and any low pin between polls
  always @(posedge mclk) begin
    if (|erase_mask) mask_seen <= erase_mask;
    if (!completion_indicator_pin) pl <= 1'b1;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic rd, input logic [31:0] d);
    int n = 0;
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    @(posedge mclk);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
    if (n >= 50) begin
      chk(32'h0, 32'h1, "bus answer");
      wrap_up();
    end
  endtask : bus

  task automatic cmd2(input logic [7:0] a, input logic [7:0] b);
    bus(4'h0, 1'b0, {24'h0, a});
    bus(4'h0, 1'b0, {24'h0, b});
  endtask : cmd2

  task automatic lk(input logic [7:0] b);
    bus(4'h4, 1'b0, 32'h1800);
    cmd2(flash_cmd_pkg::CMD_LOCK_SETUP, b);
  endtask : lk

  task automatic prog(input logic [31:0] a, input logic [7:0] c);
    bus(4'h4, 1'b0, a);
    cmd2(c, 8'h5A);
  endtask : prog

  // poll status until ready, then compare the bits under m
  task automatic ready(input logic [7:0] e, input string nm, input logic [7:0] m = 8'hFF);
    int i = 0;
    bus(4'h0, 1'b0, {24'h0, flash_cmd_pkg::CMD_READ_STATUS});
    bus(4'h8, 1'b1, 32'h0);
    while (q[7] !== 1'b1 && i < 200) begin
      bus(4'h8, 1'b1, 32'h0);
      i++;
    end
    chk({24'h0, q[7:0] & m}, {24'h0, e & m}, nm);
    if (i >= 200) wrap_up();
  endtask : ready

  task automatic locks(input logic [31:0] e);
    bus(4'hC, 1'b1, 32'h0);
    chk(q, e, "lock bits");
  endtask : locks

  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    ready(8'h80, "status after reset");
    locks(32'h0);
    write_protect_n <= 1'b0;
    lk(flash_cmd_pkg::CMD_LOCK_SET);
    ready(8'h92, "lock with protect low");
    locks(32'h0);
    cmd2(8'h50, 8'h70);
    write_protect_n <= 1'b1;
    lk(flash_cmd_pkg::CMD_LOCK_SET);
    ready(8'h80, "lock done");
    locks(32'h8);
    lk(8'hFF);
    ready(8'hB0, "bad second cycle");
    cmd2(8'h50, 8'h70);
    $display("lock tests done");
    // chip erase skips the locked block only while protect is low
    for (int w = 0; w < 2; w++) begin
      write_protect_n <= w[0];
      mask_seen <= 32'h0;
      cmd2(flash_cmd_pkg::CMD_CHIP_ERASE, flash_cmd_pkg::CMD_CONFIRM);
      ready(8'h80, "chip erase", 8'h80);
      chk(mask_seen, w ? 32'hFFFFFFFF : 32'hFFFFFFF7, "erase mask");
      cmd2(8'h50, 8'h70);
    end
    write_protect_n <= 1'b0;
    prog(32'h1800, flash_cmd_pkg::CMD_PROGRAM);
    ready(8'h92, "program locked block");
    cmd2(8'h50, 8'h70);
    prog(32'h4000, flash_cmd_pkg::CMD_PROGRAM);
    ready(8'h80, "program open block");
    $display("protection tests done");
    vpp_lockout <= 1'b1;
    write_protect_n <= 1'b1;
    lk(flash_cmd_pkg::CMD_CONFIRM);
    ready(8'hA8, "clear at lockout");
    locks(32'h8);
    vpp_lockout <= 1'b0;
    write_protect_n <= 1'b0;
    lk(flash_cmd_pkg::CMD_CONFIRM);
    ready(8'h80, "clear with protect low", 8'h80);
    locks(32'h8);
    cmd2(8'h50, 8'h70);
    write_protect_n <= 1'b1;
    lk(flash_cmd_pkg::CMD_CONFIRM);
    // power-down in mid clear: the host must repeat the clear
    reset_powerdown_n <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({31'h0, array_busy}, 32'h0, "busy after abort");
    reset_powerdown_n <= 1'b1;
    repeat (3) @(posedge mclk);
    ready(8'h80, "status after abort", 8'h80);
    lk(flash_cmd_pkg::CMD_CONFIRM);
    ready(8'h80, "clear done");
    locks(32'h0);
    $display("clear tests done");
    // suspend a program, read elsewhere, try a refused command, resume
    prog(32'h1800, flash_cmd_pkg::CMD_PROGRAM);
    chk({31'h0, completion_indicator_pin}, 32'h0, "pin while busy");
    bus(4'h0, 1'b0, {24'h0, flash_cmd_pkg::CMD_SUSPEND});
    ready(8'h84, "suspended");
    chk({31'h0, completion_indicator_pin}, 32'h1, "pin in suspend");
    bus(4'h0, 1'b0, {24'h0, flash_cmd_pkg::CMD_ERASE});
    bus(4'h4, 1'b0, 32'h4000);
    bus(4'h0, 1'b0, {24'h0, flash_cmd_pkg::CMD_READ_ARRAY});
    bus(4'h8, 1'b1, 32'h0);
    chk({16'h0, q[15:0]}, {16'h0, 16'h4000 ^ 16'hA5C3}, "array read");
    bus(4'h0, 1'b0, {24'h0, flash_cmd_pkg::CMD_CLEAR_STATUS});
    ready(8'h84, "erase refused");
    bus(4'h0, 1'b0, {24'h0, flash_cmd_pkg::CMD_CONFIRM});
    bus(4'h8, 1'b1, 32'h0);
    chk({24'h0, q[7:0] & 8'h84}, 32'h0, "status after resume");
    chk({31'h0, completion_indicator_pin}, 32'h0, "pin after resume");
    chk({31'h0, array_busy}, 32'h1, "busy after resume");
    ready(8'h80, "resumed program done");
    $display("suspend tests done");
    // every pulse code, one program and one erase each
    for (int c = 1; c < 4; c++) begin
      cmd2(flash_cmd_pkg::CMD_PIN_CONFIG, 8'(c));
      pl <= 1'b0;
      prog(32'h4000, flash_cmd_pkg::CMD_PROGRAM_ALT);
      ready(8'h80, "program in pulse mode");
      repeat (70) @(posedge mclk);
      chk({31'h0, pl}, {31'h0, c[1]}, "program pulse");
      pl <= 1'b0;
      cmd2(flash_cmd_pkg::CMD_CHIP_ERASE, flash_cmd_pkg::CMD_CONFIRM);
      ready(8'h80, "erase in pulse mode");
      repeat (70) @(posedge mclk);
      chk({31'h0, pl}, {31'h0, c[0]}, "erase pulse");
    end
    // reserved code is refused and the pulse mode stays
    cmd2(flash_cmd_pkg::CMD_PIN_CONFIG, 8'h84);
    ready(8'hB0, "reserved pin code");
    cmd2(8'h50, 8'h70);
    pl <= 1'b0;
    prog(32'h4000, flash_cmd_pkg::CMD_PROGRAM);
    chk({31'h0, completion_indicator_pin}, 32'h1, "pulse mode kept");
    ready(8'h80, "program after reserved code");
    repeat (70) @(posedge mclk);
    chk({31'h0, pl}, 32'h1, "pulse after reserved code");
    cmd2(flash_cmd_pkg::CMD_PIN_CONFIG, 8'h00);
    $display("pin mode tests done");
    wrap_up();
  end
endmodule : flash_lock_suspend_command_logic_test

bind flash_lock_suspend_command_logic flash_lock_monitor #(.NBLK(NBLK)) flash_lock_monitor_inst (
  .mclk, .rstn, .address, .read, .write, .writedata, .readdata, .waitrequest,
  .completion_indicator_pin, .array_busy, .erase_mask);
`default_nettype wire
